// File: hdl/pccif_top.sv
//Contract
//RULE1: host address and strobes select attribute, common or I/O space
//RULE2: data bus driven on reads, sampled on host writes
//RULE3: shared memory and I/O register modes over 16-bit bus
//RULE4: interrupt request asserted while service is needed
//RULE5: interrupt line held low from reset until auto-load finishes
//RULE6: low interrupt line during init acts as busy indication
//RULE7: host I/O read strobe returns selected I/O data
//RULE8: host I/O write strobe delivers data into I/O space
//RULE9: memory write-enable strobe writes addressed card memory
//RULE10: identity, configuration and CIS loaded from nonvolatile store
//RULE11: flash 8K attribute plus 112K common, or 512-byte EEPROM
//RULE12: ring buffer 16 KB; SRAM 16 KB, or 32 KB with EEPROM
//RULE13: settings chosen only by software writes to configuration words; here the i_nv_eeprom pin sets the memory sizes and the load sets iomem[0]
//RULE14: output enable strobe returns addressed card memory data
//RULE15: card enables steer byte lanes, both high floats bus
//RULE16: register-select low means attribute or I/O, high common; here I/O strobes select I/O whatever reg_n is
//RULE17: reset pulse of at least 500 ns starts init, shorter ignored
//RULE18: write data captured during strobe, committed by its release
`timescale 1ns/1ps
`include "pccif_defines.svh"
`default_nettype none
module pccif_top (
    // clock and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_reset_n,
    // card pins
    input  wire logic                    i_card_reset,
    input  wire logic [`PCCIF_AW-1:0]    i_host_addr_lines,
    input  wire logic                    i_reg_n,
    input  wire logic                    i_ce1_n,
    input  wire logic                    i_ce2_n,
    input  wire logic                    i_oe_n,
    input  wire logic                    i_we_n,
    input  wire logic                    i_iord_n,
    input  wire logic                    i_iowr_n,
    input  wire logic [`PCCIF_DW-1:0]    i_host_data_lines,
    output logic      [`PCCIF_DW-1:0]    o_host_data_lines,
    output logic      [1:0]              o_host_data_oe,
    output logic                         o_ireq_n,
    // device side
    input  wire logic                    i_nv_eeprom,
    input  wire logic                    i_service_req,
    input  wire logic [`PCCIF_DW-1:0]    i_nv_data,
    output logic      [`PCCIF_LOAD_W-1:0] o_nv_addr,
    output logic                         o_load_done,
    output logic      [16:0]             o_nv_attr_bytes,
    output logic      [16:0]             o_nv_comm_bytes,
    output logic      [16:0]             o_sram_bytes,
    output logic      [16:0]             o_ring_bytes,
    output logic                         o_io_mode
);
    typedef enum logic [1:0] {PCCIF_S_IDLE, PCCIF_S_LOAD, PCCIF_S_RUN}
        pccif_state_t;

    // three-stage sampling of every asynchronous pin
    localparam int NP = 8 + `PCCIF_AW + `PCCIF_DW;
    // strobes and enables start at their idle high level, no false access
    localparam logic [NP-1:0] PIN_RST =
        {`PCCIF_PIN_IDLE, `PCCIF_AW'(0), `PCCIF_DW'(0)};
    logic [NP-1:0] s1, s2, s3, next_s1, next_s2, next_s3;
    logic [NP-1:0] pins;
    logic [NP-1:0] stab, next_stab;
    assign pins = {i_card_reset, i_reg_n, i_ce1_n, i_ce2_n, i_oe_n, i_we_n,
                   i_iord_n, i_iowr_n, i_host_addr_lines, i_host_data_lines};

    logic [`PCCIF_AW-1:0] a;
    logic [`PCCIF_DW-1:0] d;
    logic crst, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n;
    assign {crst, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, a, d} =
        stab;

    pccif_bus_if bus ();
    assign bus.addr   = a;
    assign bus.reg_n  = reg_n;
    assign bus.oe_n   = oe_n;
    assign bus.we_n   = we_n;
    assign bus.iord_n = iord_n;
    assign bus.iowr_n = iowr_n;
    pccif_decode u_dec (.bus(bus));

    pccif_state_t              st, next_st;
    logic [`PCCIF_CNT_W-1:0]   rcnt, next_rcnt;
    logic [`PCCIF_LOAD_W-1:0]  lptr, next_lptr;
    logic [`PCCIF_DW-1:0]      iomem [`PCCIF_IO_WORDS];
    logic [`PCCIF_DW-1:0]      next_iomem [`PCCIF_IO_WORDS];
    logic [`PCCIF_DW-1:0]      mem [`PCCIF_MEM_WORDS];
    logic [`PCCIF_DW-1:0]      next_mem [`PCCIF_MEM_WORDS];
    logic                      wpend, next_wpend;
    logic                      wio, next_wio;
    logic [`PCCIF_MEM_AW-1:0]  waddr, next_waddr;
    logic [`PCCIF_DW-1:0]      wdat, next_wdat;
    logic [1:0]                wlane, next_wlane;
    logic [`PCCIF_DW-1:0]      next_dout;
    logic [1:0]                next_oe;
    logic                      next_ireq_n;

    function automatic logic [1:0] lanes(input logic c1n, input logic c2n);
        lanes = {~c2n, ~c1n}; // see RULE15
    endfunction

    function automatic logic [`PCCIF_DW-1:0] merge(
        input logic [`PCCIF_DW-1:0] old, input logic [`PCCIF_DW-1:0] nw,
        input logic [1:0] ln);
        merge = {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
    endfunction

    always_comb begin
        next_s1 = pins;
        next_s2 = s1;
        next_s3 = s2;
        // a change counts only once two later stages agree
        for (int i = 0; i < NP; i++) begin
            next_stab[i] = (s2[i] == s3[i]) ? s3[i] : stab[i];
        end
    end

    always_comb begin
        next_st     = st;
        next_rcnt   = rcnt;
        next_lptr   = lptr;
        next_iomem  = iomem;
        next_mem    = mem;
        next_wpend  = wpend;
        next_wio    = wio;
        next_waddr  = waddr;
        next_wdat   = wdat;
        next_wlane  = wlane;
        next_dout   = o_host_data_lines;
        next_oe     = 2'h0;
        next_ireq_n = !i_service_req; // see RULE4
        // short glitches never reach the count threshold
        if (crst) begin // see RULE17
            if (rcnt != `PCCIF_CNT_W'(`PCCIF_RST_CYC)) begin
                next_rcnt = rcnt + `PCCIF_CNT_W'(1);
            end
        end else begin
            next_rcnt = '0;
        end
        if (!crst && rcnt == `PCCIF_CNT_W'(`PCCIF_RST_CYC)) begin
            next_st   = PCCIF_S_LOAD; // see RULE17
            next_lptr = '0;
            next_wpend = 1'b0;
        end else unique case (st)
            PCCIF_S_IDLE: begin
                next_st   = PCCIF_S_LOAD;
                next_lptr = '0;
            end
            PCCIF_S_LOAD: begin
                // identity/config words land in the lowest I/O words
                next_iomem[lptr] = i_nv_data; // see RULE10
                next_lptr = lptr + `PCCIF_LOAD_W'(1);
                if (lptr == `PCCIF_LOAD_W'(`PCCIF_LOAD_WORDS - 1)) begin
                    next_st = PCCIF_S_RUN;
                end
            end
            PCCIF_S_RUN: begin
                if (bus.rd && lanes(ce1_n, ce2_n) != 2'h0) begin // see RULE2
                    next_oe = lanes(ce1_n, ce2_n); // see RULE15
                    if (bus.space == pccif_pkg::PCCIF_SP_IO) begin
                        next_dout = iomem[a[`PCCIF_IO_AW:1]]; // see RULE7
                    end else begin
                        next_dout = mem[a[`PCCIF_MEM_AW:1]]; // see RULE14
                    end
                end
                // latch during strobe, commit at release
                if (bus.wr) begin // see RULE18
                    next_wpend = 1'b1;
                    next_wio   = bus.space == pccif_pkg::PCCIF_SP_IO;
                    next_waddr = a[`PCCIF_MEM_AW:1];
                    next_wdat  = d; // see RULE2
                    next_wlane = lanes(ce1_n, ce2_n);
                end else if (wpend) begin
                    next_wpend = 1'b0;
                    if (wio) begin // see RULE8
                        next_iomem[waddr[`PCCIF_IO_AW-1:0]] = merge(
                            iomem[waddr[`PCCIF_IO_AW-1:0]], wdat, wlane);
                    end else begin // see RULE9
                        next_mem[waddr] = merge(mem[waddr], wdat, wlane);
                    end
                end
            end
            default: next_st = PCCIF_S_IDLE;
        endcase
        // busy from the edge a load starts, released with load done
        if (next_st != PCCIF_S_RUN) begin
            next_ireq_n = 1'b0; // see RULE5
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s1 <= PIN_RST;
            s2 <= PIN_RST;
            s3 <= PIN_RST;
            stab <= PIN_RST;
            st <= PCCIF_S_IDLE;
            rcnt <= '0;
            lptr <= '0;
            wpend <= 1'b0;
            wio <= 1'b0;
            waddr <= '0;
            wdat <= '0;
            wlane <= 2'h0;
            o_host_data_lines <= '0;
            o_host_data_oe <= 2'h0;
            o_ireq_n <= 1'b0;
            o_nv_addr <= '0;
            o_load_done <= 1'b0;
            o_io_mode <= 1'b0;
            o_nv_attr_bytes <= `PCCIF_ATTR_BYTES;
            o_nv_comm_bytes <= `PCCIF_COMM_BYTES;
            o_sram_bytes <= `PCCIF_SRAM16_BYTES;
            o_ring_bytes <= `PCCIF_RING_BYTES;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            stab <= next_stab;
            st <= next_st;
            rcnt <= next_rcnt;
            lptr <= next_lptr;
            wpend <= next_wpend;
            wio <= next_wio;
            waddr <= next_waddr;
            wdat <= next_wdat;
            wlane <= next_wlane;
            o_host_data_lines <= next_dout;
            o_host_data_oe <= next_oe;
            o_ireq_n <= next_ireq_n; // see RULE6
            o_nv_addr <= next_lptr;
            o_load_done <= next_st == PCCIF_S_RUN;
            // bit 0 of first loaded config word picks I/O mode
            o_io_mode <= iomem[0][0]; // see RULE3
            // EEPROM: attribute only, so SRAM doubles to 32 KB
            o_nv_attr_bytes <= i_nv_eeprom ? `PCCIF_EE_BYTES
                                           : `PCCIF_ATTR_BYTES; // see RULE11
            o_nv_comm_bytes <= i_nv_eeprom ? `PCCIF_EE_COMM_BYTES
                                           : `PCCIF_COMM_BYTES; // see RULE11
            o_sram_bytes <= i_nv_eeprom ? `PCCIF_SRAM32_BYTES
                                        : `PCCIF_SRAM16_BYTES; // see RULE12
            o_ring_bytes <= `PCCIF_RING_BYTES; // see RULE12
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < `PCCIF_IO_WORDS; i++) iomem[i] <= '0;
            for (int i = 0; i < `PCCIF_MEM_WORDS; i++) mem[i] <= '0;
        end else begin
            iomem <= next_iomem; // see RULE13
            mem <= next_mem;
        end
    end

    AST_IREQ_LOW_LOAD: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) st != PCCIF_S_RUN |-> !o_ireq_n)
        else $error("ireq not low during load"); // see RULE5
    AST_IREQ_SERVICE: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (st == PCCIF_S_RUN && $past(st) == PCCIF_S_RUN && i_service_req)
        |=> !o_ireq_n) else $error("ireq not raised"); // see RULE4
    AST_RST_START: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (!crst && rcnt == `PCCIF_CNT_W'(`PCCIF_RST_CYC)) |=> st == PCCIF_S_LOAD)
        else $error("valid reset did not restart load"); // see RULE17
    AST_LOAD_LEN: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (st == PCCIF_S_LOAD && lptr == '0) |=> (st == PCCIF_S_LOAD)[*7]
        ##1 st == PCCIF_S_RUN || $past(crst))
        else $error("load length wrong"); // see RULE10
    AST_FLOAT: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (ce1_n && ce2_n) |=> o_host_data_oe == 2'h0)
        else $error("bus driven with no card enable"); // see RULE15
    AST_NO_DRIVE_WR: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) bus.wr |=> o_host_data_oe == 2'h0)
        else $error("bus driven during write"); // see RULE2
    AST_WR_COMMIT: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) ($fell(bus.wr) && st == PCCIF_S_RUN)
        |-> wpend ##1 !wpend) else $error("write not committed"); // see RULE18
    AST_SRAM_SIZE: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) ($past(i_reset_n) && $past(i_nv_eeprom)) |->
        o_sram_bytes == `PCCIF_SRAM32_BYTES)
        else $error("sram size wrong for eeprom"); // see RULE12
endmodule
`default_nettype wire

// File: include/pccif_defines.svh
`ifndef PCCIF_DEFINES_SVH
`define PCCIF_DEFINES_SVH
`define PCCIF_AW            17
`define PCCIF_DW            16
`define PCCIF_CLK_NS        25
`define PCCIF_RST_MIN_NS    500
`define PCCIF_RST_CYC       ((`PCCIF_RST_MIN_NS + `PCCIF_CLK_NS - 1) / `PCCIF_CLK_NS)
`define PCCIF_CNT_W         6
`define PCCIF_ATTR_BYTES    17'h02000
`define PCCIF_COMM_BYTES    17'h1C000
`define PCCIF_EE_BYTES      17'h00200
`define PCCIF_EE_COMM_BYTES 17'h00000
`define PCCIF_PIN_IDLE      8'h7F
`define PCCIF_RING_BYTES    17'h04000
`define PCCIF_SRAM16_BYTES  17'h04000
`define PCCIF_SRAM32_BYTES  17'h08000
`define PCCIF_LOAD_WORDS    8
`define PCCIF_LOAD_W        3
`define PCCIF_IO_WORDS      16
`define PCCIF_IO_AW         4
`define PCCIF_MEM_WORDS     64
`define PCCIF_MEM_AW        6
`endif

// File: include/pccif_pkg.sv
package pccif_pkg;
    typedef enum logic [1:0] {
        PCCIF_SP_NONE,
        PCCIF_SP_ATTR,
        PCCIF_SP_COMM,
        PCCIF_SP_IO
    } pccif_space_t;
    typedef enum logic {
        PCCIF_NV_FLASH,
        PCCIF_NV_EEPROM
    } pccif_nv_t;
endpackage

// File: include/pccif_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pccif_bus_if;
    logic [16:0] addr;
    logic        reg_n;
    logic        oe_n;
    logic        we_n;
    logic        iord_n;
    logic        iowr_n;
    logic [1:0]  space;
    logic        rd;
    logic        wr;
    modport ctl (input addr, reg_n, oe_n, we_n, iord_n, iowr_n);
    modport dec (input addr, reg_n, oe_n, we_n, iord_n, iowr_n,
                 output space, rd, wr);
endinterface
`default_nettype wire

// File: hdl/pccif_decode.sv
`timescale 1ns/1ps
`include "pccif_defines.svh"
`default_nettype none
module pccif_decode (
    pccif_bus_if.dec bus
);
    // one strobe per cycle; I/O strobes win over memory strobes, and a read wins over a write of the same space
    always_comb begin
        bus.rd    = 1'b0;
        bus.wr    = 1'b0;
        bus.space = pccif_pkg::PCCIF_SP_NONE;
        if (!bus.iord_n || !bus.iowr_n) begin // see RULE1
            bus.space = pccif_pkg::PCCIF_SP_IO;
            bus.rd    = !bus.iord_n; // see RULE7
            bus.wr    = bus.iord_n && !bus.iowr_n; // see RULE8
        end else if (!bus.oe_n || !bus.we_n) begin
            bus.space = bus.reg_n ? pccif_pkg::PCCIF_SP_COMM
                                  : pccif_pkg::PCCIF_SP_ATTR; // see RULE16
            bus.rd    = !bus.oe_n; // see RULE14
            bus.wr    = bus.oe_n && !bus.we_n; // see RULE9
        end
    end
endmodule
`default_nettype wire

// File: tb/pccif_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pccif_host_model (
    // clock
    input  wire logic        i_mclk,
    // card pins driven by the socket
    output logic [16:0]      o_addr,
    output logic             o_reg_n,
    output logic [1:0]       o_ce_n,
    output logic [3:0]       o_stb_n,
    output logic [15:0]      o_data
);
    // strobe bits: 0 io read, 1 io write, 2 output enable, 3 write enable
    initial begin
        o_addr = 17'h00000;
        o_reg_n = 1'b1;
        o_ce_n = 2'h3;
        o_stb_n = 4'hF;
        o_data = 16'h0000;
    end
    task automatic start(input int k, input logic r, input logic [16:0] a,
                         input logic [1:0] ce, input logic [15:0] wd);
        @(posedge i_mclk);
        #2;
        o_addr = a;
        o_reg_n = r;
        o_ce_n = ce;
        o_data = wd;
        o_stb_n[k] = 1'b0;
    endtask
    // released data lines show the inverse, never a stale value
    task automatic stop();
        @(posedge i_mclk);
        #2;
        o_stb_n = 4'hF;
        o_ce_n = 2'h3;
        o_data = ~o_data;
        repeat (6) @(posedge i_mclk);
        #2;
    endtask
endmodule
`default_nettype wire

// File: tb/test_pc_card_host_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_pc_card_host_interface;
    logic        mclk, reset_n, card_reset, reg_n, ireq_n, nv_ee, svc;
    logic        load_done, io_mode;
    logic [16:0] addr, attr_b, comm_b, sram_b, ring_b;
    logic [1:0]  ce_n, hoe;
    logic [3:0]  stb_n;
    logic [15:0] hdi, hdo;
    logic [2:0]  nv_addr;
    int          error_cnt, compares, cyc;
    // nonvolatile store, pattern differs per kind so a reload shows
    wire logic [15:0] nv_data = {nv_ee ? 8'hA5 : 8'h5A, 5'h00, nv_addr};
    pccif_top pccif_top_inst (.i_mclk(mclk), .i_reset_n(reset_n),
        .i_card_reset(card_reset), .i_host_addr_lines(addr),
        .i_reg_n(reg_n), .i_ce1_n(ce_n[0]), .i_ce2_n(ce_n[1]),
        .i_oe_n(stb_n[2]), .i_we_n(stb_n[3]), .i_iord_n(stb_n[0]),
        .i_iowr_n(stb_n[1]), .i_host_data_lines(hdi),
        .o_host_data_lines(hdo), .o_host_data_oe(hoe), .o_ireq_n(ireq_n),
        .i_nv_eeprom(nv_ee), .i_service_req(svc), .i_nv_data(nv_data),
        .o_nv_addr(nv_addr), .o_load_done(load_done),
        .o_nv_attr_bytes(attr_b), .o_nv_comm_bytes(comm_b),
        .o_sram_bytes(sram_b), .o_ring_bytes(ring_b), .o_io_mode(io_mode));
    pccif_host_model pccif_host_model_inst (.i_mclk(mclk), .o_addr(addr),
        .o_reg_n(reg_n), .o_ce_n(ce_n), .o_stb_n(stb_n), .o_data(hdi));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic end_of_test();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input int k, input logic r, input logic [16:0] a,
                      input logic [1:0] ce, input logic [15:0] e);
        logic [15:0] m;
        m = {{8{~ce[1]}}, {8{~ce[0]}}};
        pccif_host_model_inst.start(k, r, a, ce, 16'h0000);
        repeat (6) @(posedge mclk);
        #2;
        chk({15'h0000, hoe}, {15'h0000, ~ce});
        chk({1'b0, hdo & m}, {1'b0, e & m});
        pccif_host_model_inst.stop();
    endtask
    task automatic wr(input int k, input logic r, input logic [16:0] a,
                      input logic [1:0] ce, input logic [15:0] d);
        pccif_host_model_inst.start(k, r, a, ce, d);
        repeat (6) @(posedge mclk);
        pccif_host_model_inst.stop();
    endtask
    // bounded wait for the load flag, ireq must stay low while loading
    task automatic wait_load(input logic v);
        int n;
        n = 0;
        while (load_done !== v && n < 30) begin
            @(posedge mclk);
            #2;
            if (load_done !== 1'b1) chk({16'h0000, ireq_n}, 17'h00000);
            n++;
        end
        chk({16'h0000, load_done}, {16'h0000, v});
    endtask
    task automatic t_load();
        wait_load(1'b1);
        chk(attr_b, 17'h02000);
        chk(comm_b, 17'h1C000);
        chk(sram_b, 17'h04000);
        chk(ring_b, 17'h04000);
        chk({16'h0000, ireq_n}, 17'h00001);
    endtask
    task automatic t_io();
        rd(0, 1'b0, 17'h00006, 2'h0, 16'h5A03);
        wr(1, 1'b0, 17'h00012, 2'h0, 16'h1234);
        wr(1, 1'b0, 17'h00012, 2'h2, 16'hFFAB);
        rd(0, 1'b0, 17'h00012, 2'h0, 16'h12AB);
        rd(0, 1'b0, 17'h00012, 2'h1, 16'h12AB);
        rd(0, 1'b0, 17'h00012, 2'h3, 16'h0000);
    endtask
    task automatic t_mem();
        wr(3, 1'b1, 17'h00012, 2'h0, 16'hBEEF);
        rd(2, 1'b1, 17'h00012, 2'h0, 16'hBEEF);
        rd(0, 1'b0, 17'h00012, 2'h0, 16'h12AB);
    endtask
    task automatic t_mode();
        chk({16'h0000, io_mode}, 17'h00000);
        wr(1, 1'b0, 17'h00000, 2'h0, 16'h0001);
        chk({16'h0000, io_mode}, 17'h00001);
    endtask
    task automatic t_irq();
        svc = 1'b1;
        repeat (3) @(posedge mclk);
        #2;
        chk({16'h0000, ireq_n}, 17'h00000);
        svc = 1'b0;
        repeat (3) @(posedge mclk);
        #2;
        chk({16'h0000, ireq_n}, 17'h00001);
    endtask
    task automatic t_card();
        nv_ee = 1'b1;
        card_reset = 1'b1;
        repeat (10) @(posedge mclk);
        #2;
        card_reset = 1'b0;
        repeat (12) @(posedge mclk);
        #2;
        chk({16'h0000, load_done}, 17'h00001);
        card_reset = 1'b1;
        repeat (30) @(posedge mclk);
        #2;
        card_reset = 1'b0;
        wait_load(1'b0);
        wait_load(1'b1);
        chk(attr_b, 17'h00200);
        chk(comm_b, 17'h00000);
        chk(sram_b, 17'h08000);
        chk({16'h0000, io_mode}, 17'h00000);
        rd(0, 1'b0, 17'h00006, 2'h0, 16'hA503);
    endtask
    initial begin
        error_cnt = 0;
        compares = 0;
        cyc = 0;
        reset_n = 1'b0;
        card_reset = 1'b0;
        nv_ee = 1'b0;
        svc = 1'b0;
        repeat (5) @(posedge mclk);
        #2;
        reset_n = 1'b1;
        t_load();
        t_io();
        t_mem();
        t_mode();
        t_irq();
        t_card();
        end_of_test();
    end
endmodule
`default_nettype wire
